// [design/ies_interrupt_entry_sequencer.sv]
// Interrupt and reset entry sequencer with Avalon-MM register slave
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "ies_consts.svh"

module ies_interrupt_entry_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [`IES_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt sources
  input wire logic [`IES_NUM_SRC-1:0] src_event,
  input wire logic [`IES_NUM_SRC-1:0] src_level,
  // Fuse and lock pins
  input wire logic reset_vector_boot_fuse,
  input wire logic app_boot_lock_bit_a,
  input wire logic boot_lock_bit_b,
  // Pipeline handshake
  input wire logic instr_boundary,
  input wire ies_pkg::ies_pc_t instr_next_pc,
  input wire logic op_cli,
  input wire logic op_sei,
  input wire logic op_return_from_handler,
  input wire logic sleeping,
  input wire logic wake_done,
  // Pipeline control
  output logic irq_stall,
  output logic pc_load,
  output ies_pkg::ies_pc_t pc_load_addr,
  output ies_pkg::ies_pc_t reset_pc,
  output logic global_enable,
  output logic wake_req,
  output logic irq_taken,
  output logic [`IES_IDX_W-1:0] irq_taken_idx,
  // Stack memory port
  output logic mem_we,
  output logic mem_re,
  output logic [`IES_SP_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  import ies_pkg::*;

  // Lowest index wins; result is {valid, index}
  function automatic logic [`IES_IDX_W:0] pick(input logic [`IES_NUM_SRC-1:0] req);
    logic [`IES_IDX_W:0] r;
    r = '0;
    for (int i = `IES_NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        r = {1'b1, i[`IES_IDX_W-1:0]};
      end
    end
    return r;
  endfunction

  // Source i sits one stride above the previous vector; reset holds slot zero
  function automatic ies_pc_t vec_addr(input logic [`IES_IDX_W-1:0] idx, input ies_pc_t base);
    ies_pc_t slot;
    slot = {{(`IES_PC_W-`IES_IDX_W){1'b0}}, idx} + 15'h0001;
    return base + slot * `IES_VEC_STRIDE;
  endfunction

  // Byte-lane merge for registers up to 16 bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] data,
                                             input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
    begin
      r[7:0] = data[7:0];
    end
    if (be[1])
    begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // Pin synchronisers; stage one feeds stage two only
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic fuse_s;
  logic lock_a_s;
  logic lock_b_s;

  // Register state
  logic vsel;
  logic [`IES_NUM_SRC-1:0] enable;
  logic [`IES_NUM_SRC-1:0] flags;
  logic [`IES_SP_W-1:0] sp;
  ies_pc_t boot_base;

  // Sequencer state
  ies_state_t state;
  ies_state_t next_state;
  logic [2:0] wake_cnt;
  logic [`IES_IDX_W-1:0] win_idx;
  ies_pc_t ret_pc;
  logic [6:0] pop_hi;

  // Combinational terms
  logic bus_wr;
  logic [`IES_NUM_SRC-1:0] flag_type;
  logic [`IES_NUM_SRC-1:0] pending;
  logic [`IES_NUM_SRC-1:0] requests;
  logic [`IES_NUM_SRC-1:0] hw_clr;
  logic [`IES_NUM_SRC-1:0] sw_clr;
  logic [`IES_IDX_W:0] win;
  logic req_any;
  logic in_boot;
  logic lock_block;
  logic can_take;
  logic take_now;
  logic sleep_wake;
  logic wake_enter;
  logic enter_now;
  ies_pc_t ret_src;
  ies_pc_t vec_base;
  logic [31:0] read_mux;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= {boot_lock_bit_b, app_boot_lock_bit_a, reset_vector_boot_fuse};
      pin_sync <= pin_meta;
    end
  end

  assign fuse_s = pin_sync[0];
  assign lock_a_s = pin_sync[1];
  assign lock_b_s = pin_sync[2];

  // Pending and request resolution
  assign flag_type = ~`IES_LEVEL_SRC;
  assign pending = (flags & flag_type) | (src_level & `IES_LEVEL_SRC);
  assign requests = pending & enable;
  assign win = pick(requests);
  assign req_any = win[`IES_IDX_W];
  assign in_boot = instr_next_pc >= boot_base;
  // Lock bit A mutes all sources for boot vectors while app code runs; lock bit B for app vectors while boot code runs
  assign lock_block = (lock_a_s && vsel && !in_boot) || (lock_b_s && !vsel && in_boot);
  assign can_take = global_enable && !op_cli && req_any && !lock_block;
  // Only at a boundary, so a multi-cycle instruction always completes first
  assign take_now = (state == IES_IDLE) && instr_boundary && !sleeping && can_take;
  assign sleep_wake = (state == IES_IDLE) && sleeping && can_take;
  assign wake_enter = (state == IES_WAKE_X) && (wake_cnt == 3'h1) && global_enable && req_any && !lock_block;
  assign enter_now = take_now || wake_enter;
  assign ret_src = (state == IES_IDLE) ? instr_next_pc : ret_pc;
  assign vec_base = vsel ? boot_base : `IES_RESET_VEC;
  assign bus_wr = avs_write && !avs_waitrequest;
  assign sw_clr = (bus_wr && (avs_address == `IES_OFF_FLAGS) && avs_byteenable[0]) ?
                  avs_writedata[`IES_NUM_SRC-1:0] : '0;
  assign hw_clr = enter_now ? (flag_type & (`IES_NUM_SRC'(1) << win[`IES_IDX_W-1:0])) : '0;

  always_comb
  begin
    next_state = state;
    case (state)
      IES_IDLE:
      begin
        if (take_now)
        begin
          next_state = IES_ENTRY1;
        end
        else if (sleep_wake)
        begin
          next_state = IES_WAKE;
        end
        else if (op_return_from_handler && instr_boundary)
        begin
          next_state = IES_RET1;
        end
      end
      IES_WAKE:
      begin
        if (wake_done)
        begin
          next_state = IES_WAKE_X;
        end
      end
      IES_WAKE_X:
      begin
        if (wake_cnt == 3'h1)
        begin
          next_state = wake_enter ? IES_ENTRY1 : IES_IDLE;
        end
      end
      IES_ENTRY1: next_state = IES_ENTRY2;
      IES_ENTRY2: next_state = IES_ENTRY3;
      IES_ENTRY3: next_state = IES_ENTRY4;
      IES_ENTRY4: next_state = IES_IDLE;
      IES_RET1: next_state = IES_RET2;
      IES_RET2: next_state = IES_RET3;
      IES_RET3: next_state = IES_RET4;
      IES_RET4: next_state = IES_IDLE;
      default: next_state = IES_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= IES_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Extra wake-up cycles run only after the sleep start-up has ended
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_cnt <= 3'h0;
    end
    else if (state == IES_WAKE && wake_done)
    begin
      wake_cnt <= `IES_SLEEP_EXTRA_CYC;
    end
    else if (wake_cnt != 3'h0)
    begin
      wake_cnt <= wake_cnt - 3'h1;
    end
  end

  // Winner and return address are frozen at entry so late requests cannot redirect it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      win_idx <= '0;
      ret_pc <= `IES_RESET_VEC;
    end
    else
    begin
      if (enter_now)
      begin
        win_idx <= win[`IES_IDX_W-1:0];
      end
      if (state == IES_IDLE && (take_now || sleep_wake))
      begin
        ret_pc <= instr_next_pc;
      end
    end
  end

  // Flags: a new event beats any clear in the same cycle
  generate
    for (genvar i = 0; i < `IES_NUM_SRC; i++)
    begin : g_flag
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          flags[i] <= 1'b0;
        end
        else if (flag_type[i])
        begin
          flags[i] <= src_event[i] || (flags[i] && !hw_clr[i] && !sw_clr[i]);
        end
        else
        begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Global enable; the status byte around it is never saved here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      global_enable <= 1'b0;
    end
    else if (enter_now)
    begin
      global_enable <= 1'b0;
    end
    else if (op_cli)
    begin
      global_enable <= 1'b0;
    end
    else if (state == IES_RET4)
    begin
      global_enable <= 1'b1;
    end
    else if (op_sei)
    begin
      global_enable <= 1'b1;
    end
    else if (bus_wr && avs_address == `IES_OFF_CTRL && avs_byteenable[0])
    begin
      global_enable <= avs_writedata[`IES_CTRL_GIE];
    end
  end

  // Software registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vsel <= 1'b0;
      enable <= '0;
      boot_base <= `IES_BOOT_BASE_RST;
    end
    else if (bus_wr && avs_byteenable[0])
    begin
      if (avs_address == `IES_OFF_CTRL)
      begin
        vsel <= avs_writedata[`IES_CTRL_VSEL];
      end
      else if (avs_address == `IES_OFF_ENABLE)
      begin
        enable <= avs_writedata[`IES_NUM_SRC-1:0];
      end
      else if (avs_address == `IES_OFF_BOOT_BASE)
      begin
        boot_base <= ies_pc_t'(lane_merge({1'b0, boot_base}, avs_writedata[15:0], avs_byteenable[1:0]));
      end
    end
    else if (bus_wr && avs_byteenable[1] && avs_address == `IES_OFF_BOOT_BASE)
    begin
      boot_base <= ies_pc_t'(lane_merge({1'b0, boot_base}, avs_writedata[15:0], avs_byteenable[1:0]));
    end
  end

  // Stack pointer: hardware moves win over a software write in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sp <= `IES_SP_RST;
    end
    else if (state == IES_ENTRY2)
    begin
      sp <= sp - `IES_SP_STEP;
    end
    else if (state == IES_RET2)
    begin
      sp <= sp + `IES_SP_STEP;
    end
    else if (bus_wr && avs_address == `IES_OFF_SP)
    begin
      sp <= lane_merge(sp, avs_writedata[15:0], avs_byteenable[1:0]);
    end
  end

  // Stack memory strobes; low byte at the higher address, high byte below it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= 8'h00;
    end
    else
    begin
      mem_we <= (next_state == IES_ENTRY1) || (next_state == IES_ENTRY2);
      mem_re <= (next_state == IES_RET1) || (next_state == IES_RET2);
      mem_wdata <= 8'h00;
      mem_addr <= sp;
      if (next_state == IES_ENTRY1)
      begin
        mem_wdata <= ret_src[7:0];
      end
      else if (next_state == IES_ENTRY2)
      begin
        mem_addr <= sp - 16'h0001;
        mem_wdata <= {1'b0, ret_pc[14:8]};
      end
      else if (next_state == IES_RET1)
      begin
        mem_addr <= sp + 16'h0001;
      end
      else if (next_state == IES_RET2)
      begin
        mem_addr <= sp + `IES_SP_STEP;
      end
    end
  end

  // Read data returns one cycle after each read strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pop_hi <= 7'h00;
    end
    else if (state == IES_RET2)
    begin
      pop_hi <= mem_rdata[6:0];
    end
  end

  // Pipeline control
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_stall <= 1'b0;
      pc_load <= 1'b0;
      pc_load_addr <= `IES_RESET_VEC;
      wake_req <= 1'b0;
      irq_taken <= 1'b0;
      irq_taken_idx <= '0;
    end
    else
    begin
      irq_stall <= next_state != IES_IDLE;
      pc_load <= (next_state == IES_ENTRY4) || (next_state == IES_RET4);
      if (next_state == IES_ENTRY4)
      begin
        pc_load_addr <= vec_addr(win_idx, vec_base);
      end
      else if (next_state == IES_RET4)
      begin
        pc_load_addr <= {pop_hi, mem_rdata};
      end
      wake_req <= next_state == IES_WAKE;
      irq_taken <= enter_now;
      if (enter_now)
      begin
        irq_taken_idx <= win[`IES_IDX_W-1:0];
      end
    end
  end

  // Reset vector follows the synchronised fuse after release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reset_pc <= `IES_RESET_VEC;
    end
    else
    begin
      reset_pc <= fuse_s ? boot_base : `IES_RESET_VEC;
    end
  end

  // Register read decode
  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (avs_address == `IES_OFF_CTRL)
    begin
      read_mux[`IES_CTRL_GIE] = global_enable;
      read_mux[`IES_CTRL_VSEL] = vsel;
    end
    else if (avs_address == `IES_OFF_ENABLE)
    begin
      read_mux[`IES_NUM_SRC-1:0] = enable;
    end
    else if (avs_address == `IES_OFF_FLAGS)
    begin
      read_mux[`IES_NUM_SRC-1:0] = flags;
    end
    else if (avs_address == `IES_OFF_SP)
    begin
      read_mux[15:0] = sp;
    end
    else if (avs_address == `IES_OFF_BOOT_BASE)
    begin
      read_mux[`IES_PC_W-1:0] = boot_base;
    end
    else if (avs_address == `IES_OFF_STATUS)
    begin
      read_mux[`IES_ST_PEND_LSB +: `IES_NUM_SRC] = requests;
      read_mux[`IES_ST_IDX_LSB +: `IES_IDX_W] = win_idx;
      read_mux[`IES_ST_BUSY] = state != IES_IDLE;
      read_mux[`IES_ST_LOCK] = lock_block;
      read_mux[`IES_ST_FUSE] = fuse_s;
      read_mux[`IES_ST_WAKE] = wake_req;
      read_mux[`IES_ST_STATE_LSB +: 4] = state;
    end
  end

  // One wait cycle per access keeps decode off the bus path
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        avs_readdata <= read_mux;
      end
    end
  end

endmodule

// [dv/ies_seq_checker.sv]
// Assertion checker for the interrupt entry sequencer
`timescale 1ns/1ps
`include "ies_consts.svh"
module ies_seq_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pipeline side
  input wire logic instr_boundary,
  input wire ies_pkg::ies_pc_t instr_next_pc,
  input wire logic op_cli,
  input wire logic op_sei,
  input wire logic op_return_from_handler,
  input wire logic irq_stall,
  input wire logic pc_load,
  input wire logic global_enable,
  input wire logic irq_taken,
  // Stack port
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [`IES_SP_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata
);
  import ies_pkg::*;
  ies_pc_t npc_q;
  ies_pc_t npc_held;
  logic ret_go;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  assign ret_go = op_return_from_handler && instr_boundary && !irq_stall;
  // Keeps the address seen at the take edge, since the pipeline may move on
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      npc_q <= '0;
      npc_held <= '0;
    end
    else
    begin
      npc_q <= instr_next_pc;
      npc_held <= irq_taken ? npc_q : npc_held;
    end
  end
  entry_len_a: assert property (irq_taken |-> ##3 pc_load)
    else $error("entry vector load not on time");
  entry_stall_a: assert property (irq_taken |-> irq_stall [*4])
    else $error("stall dropped during entry");
  gie_clear_a: assert property (irq_taken |-> !global_enable)
    else $error("global enable kept on entry");
  take_gate_a: assert property (irq_taken |-> $past(global_enable) && !$past(op_cli))
    else $error("entry without global enable");
  push_pair_a: assert property (irq_taken |-> mem_we ##1 (mem_we && mem_addr == $past(mem_addr) - 16'h0001))
    else $error("push addresses wrong");
  push_data_a: assert property (irq_taken |-> mem_wdata == npc_q[7:0] ##1 mem_wdata == {1'b0, npc_held[14:8]})
    else $error("pushed return address wrong");
  ret_pop_a: assert property (ret_go |=> mem_re ##1 (mem_re && mem_addr == $past(mem_addr) + 16'h0001))
    else $error("pop addresses wrong");
  ret_len_a: assert property (ret_go |-> ##4 pc_load ##1 (global_enable && !irq_stall))
    else $error("return length or enable wrong");
  sei_wait_a: assert property (op_sei |=> !irq_taken)
    else $error("entry in set-enable cycle");
  cli_block_a: assert property (op_cli |=> !global_enable && !irq_taken)
    else $error("entry after clear-enable");
endmodule

bind ies_interrupt_entry_sequencer ies_seq_checker u_chk (
  .clk(clk),
  .rst(rst),
  .instr_boundary(instr_boundary),
  .instr_next_pc(instr_next_pc),
  .op_cli(op_cli),
  .op_sei(op_sei),
  .op_return_from_handler(op_return_from_handler),
  .irq_stall(irq_stall),
  .pc_load(pc_load),
  .global_enable(global_enable),
  .irq_taken(irq_taken),
  .mem_we(mem_we),
  .mem_re(mem_re),
  .mem_addr(mem_addr),
  .mem_wdata(mem_wdata)
);

// [dv/ies_stack_mem.sv]
// Stack memory model on the far side of the sequencer
`timescale 1ns/1ps
`include "ies_consts.svh"
module ies_stack_mem (
  // Clock
  input wire logic clk,
  // Stack port
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [`IES_SP_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:511];
  initial mem_rdata = 8'h00;
  // Read data stands one cycle only; otherwise the bus toggles so stale data is never reused
  always @(posedge clk)
  begin
    if (mem_we)
      ram[mem_addr[8:0]] <= mem_wdata;
    mem_rdata <= mem_re ? ram[mem_addr[8:0]] : ~mem_rdata;
  end
endmodule

// [dv/tb_interrupt_entry_sequencer.sv]
// Self-checking testbench of the interrupt entry sequencer
`timescale 1ns/1ps
`include "ies_consts.svh"
module tb_interrupt_entry_sequencer;
  import ies_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] src_event = 8'h00;
  logic [7:0] src_level = 8'h00;
  logic reset_vector_boot_fuse = 1'b0;
  logic app_boot_lock_bit_a = 1'b0;
  logic boot_lock_bit_b = 1'b0;
  logic instr_boundary = 1'b0;
  ies_pc_t instr_next_pc = 15'h5a34;
  logic op_cli = 1'b0;
  logic op_sei = 1'b0;
  logic op_return_from_handler = 1'b0;
  logic sleeping = 1'b0;
  logic wake_done = 1'b0;
  logic irq_stall, pc_load, global_enable, wake_req, irq_taken, mem_we, mem_re;
  ies_pc_t pc_load_addr, reset_pc;
  logic [2:0] irq_taken_idx;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [31:0] rd;
  int n;
  int miscompares = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  ies_interrupt_entry_sequencer DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_event(src_event),
    .src_level(src_level), .reset_vector_boot_fuse(reset_vector_boot_fuse),
    .app_boot_lock_bit_a(app_boot_lock_bit_a), .boot_lock_bit_b(boot_lock_bit_b),
    .instr_boundary(instr_boundary), .instr_next_pc(instr_next_pc), .op_cli(op_cli), .op_sei(op_sei),
    .op_return_from_handler(op_return_from_handler), .sleeping(sleeping), .wake_done(wake_done), .irq_stall(irq_stall), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .reset_pc(reset_pc), .global_enable(global_enable), .wake_req(wake_req),
    .irq_taken(irq_taken), .irq_taken_idx(irq_taken_idx), .mem_we(mem_we), .mem_re(mem_re),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  ies_stack_mem u_mem (.clk(clk), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task tmo;
    miscompares++;
    end_of_test;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Values seen just after an edge are those sampled at it, since the design updates later
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0)
      tmo;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task pulse_ev(input logic [7:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= 8'h00;
  endtask
  task step(input logic cli, input logic sei, input logic return_from_handler);
    @(posedge clk);
    instr_boundary <= 1'b1;
    op_cli <= cli;
    op_sei <= sei;
    op_return_from_handler <= return_from_handler;
    @(posedge clk);
    instr_boundary <= 1'b0;
    op_cli <= 1'b0;
    op_sei <= 1'b0;
    op_return_from_handler <= 1'b0;
  endtask
  task wait_load;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pc_load !== 1'b1 && n < 20);
    if (pc_load !== 1'b1)
      tmo;
  endtask
  // Looked at inside the would-be entry, since the stall ends after four cycles
  task idle_chk;
    repeat (2) @(posedge clk);
    chk(32'(irq_stall), 32'h0);
  endtask
  task ret;
    step(1'b0, 1'b0, 1'b1);
    wait_load;
    chk(32'(n), 32'h4);
  endtask
  task t_reset;
    chk(32'(reset_pc), 32'h0);
    rd_chk(`IES_OFF_BOOT_BASE, 32'h7000);
    bus(1'b1, 5'h18, 32'hff);
    rd_chk(5'h18, 32'h0);
  endtask
  task t_entry;
    bus(1'b1, `IES_OFF_SP, 32'h0100);
    pulse_ev(8'h08);
    rd_chk(`IES_OFF_FLAGS, 32'h08);
    bus(1'b1, `IES_OFF_CTRL, 32'h1);
    step(1'b0, 1'b0, 1'b0);
    idle_chk;
    bus(1'b1, `IES_OFF_ENABLE, 32'h08);
    step(1'b0, 1'b0, 1'b0);
    wait_load;
    chk(32'(n), 32'h4);
    chk(32'(pc_load_addr), 32'h8);
    chk(32'(global_enable), 32'h0);
    chk(32'(u_mem.ram[9'h100]), 32'h34);
    chk(32'(u_mem.ram[9'h0ff]), 32'h5a);
    rd_chk(`IES_OFF_SP, 32'h00fe);
    rd_chk(`IES_OFF_FLAGS, 32'h0);
  endtask
  task t_return;
    ret;
    chk(32'(pc_load_addr), 32'h5a34);
    @(posedge clk);
    chk(32'(global_enable), 32'h1);
    rd_chk(`IES_OFF_SP, 32'h0100);
  endtask
  task t_prio;
    bus(1'b1, `IES_OFF_CTRL, 32'h0);
    bus(1'b1, `IES_OFF_ENABLE, 32'h22);
    pulse_ev(8'h22);
    bus(1'b1, `IES_OFF_CTRL, 32'h1);
    step(1'b0, 1'b0, 1'b0);
    wait_load;
    chk(32'(pc_load_addr), 32'h4);
    rd_chk(`IES_OFF_FLAGS, 32'h20);
    ret;
    repeat (4) @(posedge clk);
    chk(32'(irq_stall), 32'h0);
    step(1'b0, 1'b0, 1'b0);
    wait_load;
    chk(32'(pc_load_addr), 32'hc);
    ret;
  endtask
  task t_clear;
    bus(1'b1, `IES_OFF_CTRL, 32'h0);
    bus(1'b1, `IES_OFF_ENABLE, 32'h0);
    pulse_ev(8'h44);
    bus(1'b1, `IES_OFF_FLAGS, 32'h0);
    rd_chk(`IES_OFF_FLAGS, 32'h44);
    bus(1'b1, `IES_OFF_FLAGS, 32'h04);
    rd_chk(`IES_OFF_FLAGS, 32'h40);
  endtask
  task t_cli;
    bus(1'b1, `IES_OFF_ENABLE, 32'h40);
    bus(1'b1, `IES_OFF_CTRL, 32'h1);
    step(1'b1, 1'b0, 1'b0);
    idle_chk;
    chk(32'(global_enable), 32'h0);
    step(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    chk(32'(irq_stall), 32'h0);
    step(1'b0, 1'b0, 1'b0);
    wait_load;
    chk(32'(pc_load_addr), 32'he);
    ret;
  endtask
  task t_vsel;
    bus(1'b1, `IES_OFF_CTRL, 32'h2);
    bus(1'b1, `IES_OFF_ENABLE, 32'h01);
    pulse_ev(8'h01);
    bus(1'b1, `IES_OFF_CTRL, 32'h3);
    step(1'b0, 1'b0, 1'b0);
    wait_load;
    chk(32'(pc_load_addr), 32'h7002);
    ret;
    bus(1'b1, `IES_OFF_CTRL, 32'h0);
  endtask
  task t_level;
    bus(1'b1, `IES_OFF_ENABLE, 32'h80);
    @(posedge clk);
    src_level <= 8'h80;
    repeat (3) @(posedge clk);
    src_level <= 8'h00;
    bus(1'b1, `IES_OFF_CTRL, 32'h1);
    step(1'b0, 1'b0, 1'b0);
    idle_chk;
    src_level <= 8'h80;
    step(1'b0, 1'b0, 1'b0);
    wait_load;
    chk(32'(pc_load_addr), 32'h10);
    src_level <= 8'h00;
    ret;
  endtask
  task t_sleep;
    bus(1'b1, `IES_OFF_ENABLE, 32'h02);
    pulse_ev(8'h02);
    @(posedge clk);
    sleeping <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(wake_req), 32'h1);
    wake_done <= 1'b1;
    sleeping <= 1'b0;
    @(posedge clk);
    wake_done <= 1'b0;
    wait_load;
    chk(32'(n), 32'h8);
    chk(32'(irq_taken_idx), 32'h1);
    chk(32'(pc_load_addr), 32'h4);
    ret;
  endtask
  task t_lock;
    @(posedge clk);
    app_boot_lock_bit_a <= 1'b1;
    bus(1'b1, `IES_OFF_ENABLE, 32'h01);
    bus(1'b1, `IES_OFF_CTRL, 32'h3);
    pulse_ev(8'h01);
    step(1'b0, 1'b0, 1'b0);
    idle_chk;
    app_boot_lock_bit_a <= 1'b0;
    repeat (2) @(posedge clk);
    step(1'b0, 1'b0, 1'b0);
    wait_load;
    chk(32'(pc_load_addr), 32'h7002);
    ret;
    bus(1'b1, `IES_OFF_CTRL, 32'h0);
  endtask
  task t_fuse;
    @(posedge clk);
    reset_vector_boot_fuse <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(reset_pc), 32'h7000);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_entry;
    t_return;
    t_prio;
    t_clear;
    t_cli;
    t_vsel;
    t_level;
    t_sleep;
    t_lock;
    t_fuse;
    end_of_test;
  end
endmodule

// [inc/ies_consts.svh]
// Constants for the interrupt entry sequencer
// Overview of operation
// - Reset and every source own a vector
// - Take only with source and global enable
// - Lowest vector address wins, reset first
// - Vector select bit moves table to boot
// - Boot fuse moves reset vector to boot
// - Boot lock bits may suppress by location
// - Entry clears global enable; software re-enables
// - Return: four cycles, pop, stack+2, enable
// - Vectoring clears flag-type source flag
// - Writing one clears flag, zero keeps
// - Flag set and held while source disabled
// - Flags pending under global disable serve later
// - Level sources request only while present
// - One instruction runs after return first
// - Status byte never saved nor restored
// - Clear-enable instruction blocks immediately
// - Instruction after set-enable runs first
// - Entry four cycles, pushes counter, vectors
// - Multi-cycle instruction finishes before entry
// - Wake from sleep adds four cycles
// - Program counter fifteen bits, 32K words
// - Entry push decrements stack by two
`ifndef IES_CONSTS_SVH
`define IES_CONSTS_SVH

`define IES_NUM_SRC 8
`define IES_IDX_W 3
`define IES_PC_W 15
`define IES_SP_W 16
`define IES_ADDR_W 5

`define IES_RESET_VEC 15'h0000
`define IES_VEC_STRIDE 15'h0002
`define IES_BOOT_BASE_RST 15'h7000
`define IES_SP_RST 16'h0000
`define IES_SP_STEP 16'h0002
`define IES_LEVEL_SRC 8'h80

`define IES_OFF_CTRL 5'h00
`define IES_OFF_ENABLE 5'h04
`define IES_OFF_FLAGS 5'h08
`define IES_OFF_SP 5'h0c
`define IES_OFF_BOOT_BASE 5'h10
`define IES_OFF_STATUS 5'h14

`define IES_CTRL_GIE 0
`define IES_CTRL_VSEL 1

`define IES_ST_PEND_LSB 0
`define IES_ST_IDX_LSB 8
`define IES_ST_BUSY 12
`define IES_ST_LOCK 13
`define IES_ST_FUSE 14
`define IES_ST_WAKE 15
`define IES_ST_STATE_LSB 16

`define IES_ENTRY_CYC 4
`define IES_RET_CYC 4
`define IES_SLEEP_EXTRA_CYC 3'h4

`endif

// [inc/ies_pkg.sv]
// Types shared by the interrupt entry sequencer
package ies_pkg;
  typedef logic [14:0] ies_pc_t;
  typedef enum logic [3:0] {
    IES_IDLE,
    IES_WAKE,
    IES_WAKE_X,
    IES_ENTRY1,
    IES_ENTRY2,
    IES_ENTRY3,
    IES_ENTRY4,
    IES_RET1,
    IES_RET2,
    IES_RET3,
    IES_RET4
  } ies_state_t;
endpackage
